// File: verilog/vram_cycle_host.sv
/*
  apb-driven controller that runs strobe cycles of a dual-port video dram.
  assumes the device pins are wired straight to the strobe and data ports
  and that the testbench resolves the two-way pins from the enables.
*/
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ns
module vram_cycle_host
  import vram_host_pkg::*;
#(
  parameter int AW = ADDR_BITS,
  parameter int DW = DATA_BITS
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic rowStrobe_n,
  output logic colStrobe_n,
  output logic [AW-1:0] address,
  output logic write_mode_select,
  output logic transfer_output_select,
  output logic special_function_select,
  output logic shift_output_gate,
  output logic shift_clock,
  input wire logic [DW-1:0] maskDataIn,
  output logic [DW-1:0] maskDataOut,
  output logic maskDataOe,
  input wire logic [DW-1:0] shiftDataIn,
  output logic [DW-1:0] shiftDataOut,
  output logic shiftDataOe,
  input wire logic half_indicator
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    S_IDLE = 6'b000001, S_ROW = 6'b000010, S_ROWHOLD = 6'b000100,
    S_COL = 6'b001000, S_HOLD = 6'b010000, S_PRE = 6'b100000
  } state_t;
  state_t state;
  op_t op;
  logic busy;
  logic [AW-1:0] rowAddr, colAddr;
  logic [DW-1:0] wrData, maskBits, readData;
  logic serialGate, serialWrite, serialInput;
  logic [DW-1:0] serialData, serialRead;
  logic [7:0] count;
  logic shiftStart, shiftIdle;
  logic wrAcc, rdAcc;

  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wrAcc = psel && penable && pwrite;
  assign rdAcc = psel && penable && !pwrite;
  assign shiftStart = wrAcc && paddr == CMD_OFFSET && pwdata[CMD_GO_BIT]
    && !busy && op_t'(pwdata[CMD_CODE_LSB +: 4]) == OP_SERIAL_STEP;

  function automatic logic isTransfer(input op_t o);
    isTransfer = o inside {OP_ARRAY_TO_BUFFER_COPY, OP_HALF_BUFFER_LOAD,
      OP_DIRECTION_FLIP_CYCLE, OP_MASKED_BUFFER_TO_ARRAY,
      OP_MASKED_HALF_TO_ARRAY};
  endfunction
  function automatic logic hasColumn(input op_t o);
    hasColumn = !(o inside {OP_COLUMN_FIRST_REFRESH, OP_ROW_ONLY_REFRESH,
      OP_MASKED_FLASH_FILL, OP_LOAD_FILL_VALUE});
  endfunction

  // ----------------------------------------------------------------
  // apb writes
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      op <= op_t'(CMD_RESET[3:0]);
      rowAddr <= '0;
      colAddr <= '0;
      wrData <= '0;
      maskBits <= '0;
      serialGate <= 1'b0;
      serialWrite <= 1'b0;
      serialData <= '0;
    end else if (wrAcc) begin
      case (paddr)
        CMD_OFFSET: begin
          if (!busy) begin
            op <= op_t'(pwdata[CMD_CODE_LSB +: 4]);
          end
        end
        ADDR_OFFSET: begin
          rowAddr <= pwdata[AW-1:0];
          colAddr <= pwdata[16 +: AW];
        end
        DATA_OFFSET: begin
          wrData <= pwdata[DW-1:0];
          maskBits <= pwdata[8 +: DW];
        end
        SERIAL_OFFSET: begin
          serialGate <= pwdata[8];
          serialWrite <= pwdata[9];
          serialData <= pwdata[DW-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // apb reads
  // ----------------------------------------------------------------
  always_comb begin
    case (paddr)
      CMD_OFFSET: prdata = {28'h0, op};
      ADDR_OFFSET: prdata = {7'h0, colAddr, 7'h0, rowAddr};
      DATA_OFFSET: prdata = {16'h0, maskBits, wrData};
      STATUS_OFFSET: prdata = {28'h0, serialInput, half_indicator,
        !shiftIdle, busy};
      RDATA_OFFSET: prdata = {24'h0, readData};
      SERIAL_OFFSET: prdata = {22'h0, serialWrite, serialGate, serialRead};
      default: prdata = 32'h0;
    endcase
  end

  // ----------------------------------------------------------------
  // strobe sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state <= S_IDLE;
      busy <= 1'b0;
      count <= 8'h0;
    end else begin
      case (state)
        S_IDLE: begin
          if (wrAcc && paddr == CMD_OFFSET && pwdata[CMD_GO_BIT]
              && op_t'(pwdata[CMD_CODE_LSB +: 4]) != OP_SERIAL_STEP
              && shiftIdle) begin
            state <= S_ROW;
            busy <= 1'b1;
          end
        end
        S_ROW: begin
          state <= S_ROWHOLD;
          count <= 8'(ROW_HOLD_CYC + 1); // first hold edge is the fall
        end
        S_ROWHOLD: begin
          if (count > 8'h1) begin
            count <= count - 8'h1;
          end else if (hasColumn(op)) begin
            state <= S_COL;
          end else begin
            state <= S_HOLD;
            count <= 8'(STROBE_LOW_CYC);
          end
        end
        S_COL: begin
          state <= S_HOLD;
          count <= 8'(STROBE_LOW_CYC);
        end
        S_HOLD: begin
          if (count > 8'h1) begin
            count <= count - 8'h1;
          end else begin
            state <= S_PRE;
            count <= 8'(PRECHARGE_CYC);
          end
        end
        S_PRE: begin
          if (count > 8'h1) begin
            count <= count - 8'h1;
          end else begin
            state <= S_IDLE;
            busy <= 1'b0;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pin drive; control set up one cycle before the row fall
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rowStrobe_n <= 1'b1;
      colStrobe_n <= 1'b1;
      address <= '0;
      write_mode_select <= 1'b1;
      transfer_output_select <= 1'b1;
      special_function_select <= 1'b0;
      maskDataOut <= '0;
      maskDataOe <= 1'b0;
    end else begin
      case (state)
        S_IDLE: begin
          rowStrobe_n <= 1'b1;
          colStrobe_n <= 1'b1;
          maskDataOe <= 1'b0;
          write_mode_select <= 1'b1;
          transfer_output_select <= 1'b1;
          special_function_select <= 1'b0;
        end
        S_ROW: begin
          address <= rowAddr;
          colStrobe_n <= !(op == OP_COLUMN_FIRST_REFRESH);
          transfer_output_select <= !isTransfer(op);
          write_mode_select <= !(op inside {OP_MASKED_WRITE,
            OP_MASKED_FLASH_FILL, OP_MASKED_COLUMN_FILL,
            OP_DIRECTION_FLIP_CYCLE, OP_MASKED_BUFFER_TO_ARRAY,
            OP_MASKED_HALF_TO_ARRAY});
          special_function_select <= op inside {OP_MASKED_FLASH_FILL,
            OP_LOAD_FILL_VALUE, OP_HALF_BUFFER_LOAD,
            OP_MASKED_HALF_TO_ARRAY};
          maskDataOut <= (op == OP_LOAD_FILL_VALUE) ? wrData : maskBits;
          maskDataOe <= op != OP_COLUMN_FIRST_REFRESH
            && op != OP_ROW_ONLY_REFRESH && op != OP_READ;
        end
        S_ROWHOLD: begin
          rowStrobe_n <= 1'b0;
          if (count == 8'h1 && hasColumn(op)) begin
            address <= colAddr;
            special_function_select <= op inside {OP_COLUMN_FILL_WRITE,
              OP_MASKED_COLUMN_FILL};
            maskDataOut <= wrData;
            maskDataOe <= op != OP_READ && !isTransfer(op);
            write_mode_select <= (op == OP_READ) ? 1'b1 : 1'b0;
          end
        end
        S_COL: begin
          colStrobe_n <= 1'b0;
        end
        S_HOLD: begin
          if (count == 8'h1) begin
            rowStrobe_n <= 1'b1;
            colStrobe_n <= 1'b1;
            maskDataOe <= 1'b0;
          end
        end
        S_PRE: begin
          rowStrobe_n <= 1'b1;
          colStrobe_n <= 1'b1;
        end
        default: begin
          rowStrobe_n <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // gate held over the row fall picks flip or masked buffer write
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      shift_output_gate <= 1'b0;
    end else if (state == S_ROW) begin
      shift_output_gate <= (op == OP_DIRECTION_FLIP_CYCLE) ? 1'b1
        : (op == OP_MASKED_BUFFER_TO_ARRAY) ? 1'b0 : serialGate;
    end else if (state == S_IDLE) begin
      shift_output_gate <= serialGate;
    end
  end

  // ----------------------------------------------------------------
  // read capture late in the strobe low time
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      readData <= '0;
    end else if (state == S_HOLD && count == 8'h1 && op == OP_READ) begin
      readData <= maskDataIn;
    end
  end

  // ----------------------------------------------------------------
  // serial direction mirrors the device after each transfer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      serialInput <= 1'b0;
    end else if (state == S_ROW) begin
      if (op inside {OP_ARRAY_TO_BUFFER_COPY, OP_HALF_BUFFER_LOAD}) begin
        serialInput <= 1'b0;
      end else if (op inside {OP_DIRECTION_FLIP_CYCLE,
          OP_MASKED_BUFFER_TO_ARRAY}) begin
        serialInput <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      shiftDataOut <= '0;
      shiftDataOe <= 1'b0;
      serialRead <= '0;
    end else begin
      shiftDataOut <= serialData;
      shiftDataOe <= serialInput && serialWrite && !busy;
      if (shiftStart && !serialInput) begin
        serialRead <= shiftDataIn;
      end
    end
  end

  shift_clock_gen u_shift (
    .core_clk(core_clk),
    .reset(reset),
    .start(shiftStart),
    .shiftClock(shift_clock),
    .idle(shiftIdle)
  );
endmodule

// File: include/vram_host_pkg.sv
/*
  package for the video dram cycle controller: apb register map, command
  codes, field positions and strobe timing counts.
  assumes a 100 mhz core clock.
*/
package vram_host_pkg;
  // ----------------------------------------------------------------
  // apb register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_OFFSET = 8'h00;
  localparam logic [7:0] ADDR_OFFSET = 8'h04;
  localparam logic [7:0] DATA_OFFSET = 8'h08;
  localparam logic [7:0] STATUS_OFFSET = 8'h0c;
  localparam logic [7:0] RDATA_OFFSET = 8'h10;
  localparam logic [7:0] SERIAL_OFFSET = 8'h14;
  // ----------------------------------------------------------------
  // command register fields
  // ----------------------------------------------------------------
  localparam int CMD_CODE_LSB = 0;
  localparam int CMD_GO_BIT = 31;
  localparam logic [31:0] CMD_RESET = 32'h0000_0000;
  // ----------------------------------------------------------------
  // cycle codes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_COLUMN_FIRST_REFRESH = 4'h0,
    OP_ROW_ONLY_REFRESH = 4'h1,
    OP_READ = 4'h2,
    OP_WRITE = 4'h3,
    OP_MASKED_WRITE = 4'h4,
    OP_MASKED_FLASH_FILL = 4'h5,
    OP_COLUMN_FILL_WRITE = 4'h6,
    OP_MASKED_COLUMN_FILL = 4'h7,
    OP_LOAD_FILL_VALUE = 4'h8,
    OP_ARRAY_TO_BUFFER_COPY = 4'h9,
    OP_HALF_BUFFER_LOAD = 4'ha,
    OP_DIRECTION_FLIP_CYCLE = 4'hb,
    OP_MASKED_BUFFER_TO_ARRAY = 4'hc,
    OP_MASKED_HALF_TO_ARRAY = 4'hd,
    OP_SERIAL_STEP = 4'he
  } op_t;
  // ----------------------------------------------------------------
  // timing, ns and cycles
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int ROW_HOLD_NS = 20;
  localparam int COL_HOLD_NS = 30;
  localparam int STROBE_LOW_NS = 80;
  localparam int PRECHARGE_NS = 60;
  localparam int ROW_HOLD_CYC =
    (ROW_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int COL_HOLD_CYC =
    (COL_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_LOW_CYC =
    (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRECHARGE_CYC =
    (PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ADDR_BITS = 9;
  localparam int DATA_BITS = 8;
endpackage

// File: verilog/shift_clock_gen.sv
/*
  shift clock generator: one high-low pulse of the serial clock per request.
  assumes requests only while idle is high.
*/
`timescale 1ns/1ns
module shift_clock_gen
  import vram_host_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic start,
  output logic shiftClock,
  output logic idle
);
  // ----------------------------------------------------------------
  // four-phase pulse
  // ----------------------------------------------------------------
  logic [1:0] phase;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      phase <= 2'h0;
    end else if (phase == 2'h0) begin
      if (start) begin
        phase <= 2'h1;
      end
    end else begin
      phase <= phase + 2'h1;
    end
  end
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      shiftClock <= 1'b0;
    end else begin
      shiftClock <= phase == 2'h0 && start; // one high cycle, three low
    end
  end
  assign idle = (phase == 2'h0);
endmodule

// File: sim/vram_device_model.sv
/*
  behavioural video dram: decodes strobe cycles, keeps a serial pointer.
  assumes the host drives the pins straight from its registered outputs.
*/
`timescale 1ns/1ns
module vram_device_model
  import vram_host_pkg::*;
(
  input wire logic rowStrobe_n,
  input wire logic colStrobe_n,
  input wire logic [8:0] address,
  input wire logic write_mode_select,
  input wire logic transfer_output_select,
  input wire logic special_function_select,
  input wire logic shift_output_gate,
  input wire logic shift_clock,
  input wire logic [7:0] maskDataOut,
  input wire logic maskDataOe,
  input wire logic [7:0] shiftDataOut,
  input wire logic shiftDataOe,
  output logic [7:0] maskDataIn,
  output logic [7:0] shiftDataIn,
  output logic half_indicator,
  output op_t lastOp,
  output logic [8:0] lastRow,
  output logic [8:0] lastCol,
  output logic [7:0] lastMask,
  output logic [7:0] lastColData,
  output logic [7:0] lastSerial
);
  // ------------------------------------------------------------
  // cycle decode
  // ------------------------------------------------------------
  op_t cur;
  logic colSeen, wmLow, rdDrive;
  logic outMode = 1'b0;
  logic [8:0] ptr = 9'h000; // no refresh of the buffer
  logic [7:0] rdLast = 8'h00;
  logic [7:0] serLast = 8'h00;
  wire serDrive = outMode && !shift_output_gate;
  always @(negedge rowStrobe_n) begin
    colSeen = 1'b0;
    wmLow = 1'b0;
    rdDrive = 1'b0;
    lastRow = address;
    lastMask = maskDataIn;
    if (!colStrobe_n) cur = OP_COLUMN_FIRST_REFRESH;
    else if (transfer_output_select) begin
      if (special_function_select) begin
        cur = write_mode_select ? OP_LOAD_FILL_VALUE
            : OP_MASKED_FLASH_FILL;
      end else begin
        cur = write_mode_select ? OP_READ : OP_MASKED_WRITE;
      end
    end else if (write_mode_select) begin
      cur = special_function_select ? OP_HALF_BUFFER_LOAD
          : OP_ARRAY_TO_BUFFER_COPY;
    end else if (special_function_select) cur = OP_MASKED_HALF_TO_ARRAY;
    else begin
      cur = shift_output_gate ? OP_DIRECTION_FLIP_CYCLE
          : OP_MASKED_BUFFER_TO_ARRAY;
    end
  end
  always @(negedge colStrobe_n) if (!rowStrobe_n) begin
    colSeen = 1'b1;
    lastCol = address;
    lastColData = maskDataIn;
    if (special_function_select && cur == OP_READ) begin
      cur = OP_COLUMN_FILL_WRITE;
    end
    if (special_function_select && cur == OP_MASKED_WRITE) begin
      cur = OP_MASKED_COLUMN_FILL;
    end
    rdDrive = (cur == OP_READ) && write_mode_select;
  end
  always @(negedge write_mode_select) if (!rowStrobe_n) begin
    wmLow = 1'b1;
    rdDrive = 1'b0;
  end
  always @(posedge rowStrobe_n) begin
    rdDrive = 1'b0;
    if (cur == OP_READ && !colSeen) cur = OP_ROW_ONLY_REFRESH;
    else if (cur == OP_READ && wmLow) cur = OP_WRITE;
    if (cur inside {OP_ARRAY_TO_BUFFER_COPY, OP_HALF_BUFFER_LOAD}) begin
      ptr = lastCol;
      outMode = 1'b1;
    end
    if (cur inside {OP_DIRECTION_FLIP_CYCLE, OP_MASKED_BUFFER_TO_ARRAY}) begin
      outMode = 1'b0;
    end
    lastOp = cur;
  end
  // ------------------------------------------------------------
  // pins: released lines show the inverse of their last value
  // ------------------------------------------------------------
  always @(maskDataOut, maskDataOe, rdDrive, lastRow, lastCol) begin
    if (maskDataOe) rdLast = maskDataOut;
    else if (rdDrive) rdLast = lastRow[7:0] ^ lastCol[7:0];
  end
  always @(shiftDataOut, shiftDataOe, serDrive, ptr) begin
    if (shiftDataOe) serLast = shiftDataOut;
    else if (serDrive) serLast = ptr[7:0];
  end
  assign maskDataIn = maskDataOe ? maskDataOut
      : rdDrive ? lastRow[7:0] ^ lastCol[7:0] : ~rdLast;
  assign shiftDataIn = shiftDataOe ? shiftDataOut
      : serDrive ? ptr[7:0] : ~serLast;
  assign half_indicator = ptr[8];
  always @(posedge shift_clock) begin // pointer steps even when gated
    lastSerial = shiftDataIn;
    ptr = ptr + 9'h001;
  end
endmodule

// File: sim/vram_host_checker.sv
/*
  strobe and pin timing checks on the cycle host top ports.
  assumes one core clock domain; bound to the host below.
*/
`timescale 1ns/1ns
module vram_host_checker #(
  parameter int AW = 9
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic rowStrobe_n,
  input wire logic colStrobe_n,
  input wire logic [AW-1:0] address,
  input wire logic write_mode_select,
  input wire logic shift_clock,
  input wire logic maskDataOe
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  AST_ROW_ADDR_HOLD: assert property (
    $fell(rowStrobe_n) && colStrobe_n |=> $stable(address))
    else $error("row address moved right after row strobe fell");
  AST_COL_ADDR_HOLD: assert property (
    $fell(colStrobe_n) && !rowStrobe_n |=> $stable(address))
    else $error("column address moved right after column strobe fell");
  AST_COL_BEFORE_ROW: assert property (
    $fell(rowStrobe_n) && !colStrobe_n |-> !$past(colStrobe_n))
    else $error("column strobe fell together with row strobe");
  AST_ROW_LOW_SPAN: assert property (
    $fell(rowStrobe_n) |-> !rowStrobe_n [*8])
    else $error("row strobe low too short");
  AST_PRECHARGE: assert property (
    $rose(rowStrobe_n) |-> rowStrobe_n [*6])
    else $error("row strobe precharge too short");
  AST_COL_LOW_SPAN: assert property (
    $fell(colStrobe_n) && !rowStrobe_n |-> !colStrobe_n [*8])
    else $error("column strobe low too short");
  AST_MASK_AT_ROW: assert property (
    $fell(rowStrobe_n) && colStrobe_n && !write_mode_select |-> maskDataOe)
    else $error("mask not driven at row strobe");
  AST_SHIFT_PULSE: assert property (
    $rose(shift_clock) |=> !shift_clock ##1 !shift_clock)
    else $error("shift clock pulse not one cycle");
endmodule
bind vram_cycle_host vram_host_checker #(.AW(AW)) u_vram_host_checker (
  .core_clk, .reset, .rowStrobe_n, .colStrobe_n, .address,
  .write_mode_select, .shift_clock, .maskDataOe);

// File: sim/vram_cycle_host_tb_top.sv
/*
  testbench: apb master, device model, cycle decode and serial checks.
  assumes zero-wait apb and the register map of the host package.
*/
`timescale 1ns/1ns
module vram_cycle_host_tb_top
  import vram_host_pkg::*;
;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, rowStrobe_n, colStrobe_n, write_mode_select;
  logic transfer_output_select, special_function_select, shift_output_gate;
  logic shift_clock, maskDataOe, shiftDataOe, half_indicator;
  logic [8:0] address, lastRow, lastCol;
  logic [7:0] maskDataIn, maskDataOut, shiftDataIn, shiftDataOut;
  logic [7:0] lastMask, lastColData, lastSerial;
  op_t lastOp;
  logic lastErr = 1'b0;
  int badCount = 0;
  int numChecks = 0;
  always #5 core_clk = ~core_clk;
  vram_cycle_host u_vram_cycle_host (.core_clk, .reset, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rowStrobe_n,
    .colStrobe_n, .address, .write_mode_select, .transfer_output_select,
    .special_function_select, .shift_output_gate, .shift_clock,
    .maskDataIn, .maskDataOut, .maskDataOe, .shiftDataIn, .shiftDataOut,
    .shiftDataOe, .half_indicator);
  vram_device_model u_vram_device_model (.rowStrobe_n, .colStrobe_n,
    .address, .write_mode_select, .transfer_output_select,
    .special_function_select, .shift_output_gate, .shift_clock,
    .maskDataOut, .maskDataOe, .shiftDataOut, .shiftDataOe, .maskDataIn,
    .shiftDataIn, .half_indicator, .lastOp, .lastRow, .lastCol, .lastMask,
    .lastColData, .lastSerial);
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    numChecks++;
    if (g !== e) begin
      badCount++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    q = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    apb(1'b0, a, 32'h0, q);
  endtask
  task automatic idle;
    logic [31:0] s;
    s = 32'h1;
    for (int i = 0; i < 100 && s[0] !== 1'b0; i++) rd(STATUS_OFFSET, s);
    chk("busy", 32'h0, {31'h0, s[0]});
  endtask
  task automatic go(input logic [3:0] op);
    wr(CMD_OFFSET, {1'b1, 27'h0, op});
    idle;
  endtask
  task automatic run(input logic [3:0] op, input logic [8:0] r,
                     input logic [8:0] c, input logic [31:0] d);
    wr(ADDR_OFFSET, {7'h0, c, 7'h0, r});
    wr(DATA_OFFSET, d);
    go(op);
  endtask
  task automatic results;
    if (badCount == 0 && numChecks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    logic [31:0] q;
    rd(CMD_OFFSET, q);
    chk("cmd", CMD_RESET, q);
    wr(8'h20, 32'hffff_ffff);
    chk("pslverr", 32'h0, {31'h0, lastErr});
    rd(8'h20, q);
    chk("unmapped", 32'h0, q);
    wr(ADDR_OFFSET, 32'h01a5_0123);
    rd(ADDR_OFFSET, q);
    chk("addr", 32'h01a5_0123, q);
    wr(CMD_OFFSET, 32'h8000_0002);
    wr(CMD_OFFSET, 32'h8000_0003);
    idle;
    chk("busy cmd", {28'h0, OP_READ}, {28'h0, lastOp});
  endtask
  // every strobe cycle code 0 to 13 (not the serial step), each with its own row and column
  task automatic t_decode;
    logic [31:0] q;
    logic [8:0] r, c;
    logic [7:0] m, v;
    for (int k = 0; k < 14; k++) begin
      r = {1'b1, k[3:0], 4'h3};
      c = {1'b0, 4'h6, k[3:0]};
      m = {4'h9, k[3:0]};
      v = {4'ha, k[3:0]};
      run(k[3:0], r, c, {16'h0, m, v});
      chk("op", k, 32'(lastOp));
      if (k != 0) chk("row", {23'h0, r}, {23'h0, lastRow});
      if (k inside {2, 3, 4, 6, 7, 9})
        chk("col", 32'(c), 32'(lastCol));
      if (k inside {4, 5, 7, 12, 13})
        chk("mask", 32'(m), 32'(lastMask));
      if (k inside {3, 6, 7})
        chk("coldata", 32'(v), 32'(lastColData));
      if (k == 8) chk("fill", 32'(v), 32'(lastMask));
      if (k == 2) begin
        rd(RDATA_OFFSET, q);
        chk("rdata", {24'h0, r[7:0] ^ c[7:0]}, {24'h0, q[7:0]});
      end
    end
  endtask
  // tap just below the half boundary, then step across it
  task automatic t_serial;
    logic [31:0] q;
    wr(SERIAL_OFFSET, 32'h0);
    run(4'h9, 9'h010, 9'h0fe, 32'h0);
    rd(STATUS_OFFSET, q);
    chk("half dir", 32'h0, {28'h0, q[3:2], 2'h0});
    go(4'he);
    rd(SERIAL_OFFSET, q);
    chk("serial rd", 32'hfe, {24'h0, q[7:0]});
    wr(SERIAL_OFFSET, 32'h100);
    go(4'he);
    rd(STATUS_OFFSET, q);
    chk("half gated", 32'h1, {31'h0, q[2]});
    run(4'hb, 9'h020, 9'h000, 32'h0);
    rd(STATUS_OFFSET, q);
    chk("input mode", 32'h1, {31'h0, q[3]});
    wr(SERIAL_OFFSET, 32'h277);
    go(4'he);
    chk("serial in", 32'h77, {24'h0, lastSerial});
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    t_regs;
    t_decode;
    t_serial;
    results;
  end
  initial begin
    #400000;
    badCount++;
    results;
  end
endmodule
